// ==== hw/svc_defines.svh ====
// Offsets, field positions, identity value and timing counts of the debug service block.
// Assumes a 32-bit AXI4-Lite register port; included by the design file and the bench.
`ifndef SVC_DEFINES_SVH
`define SVC_DEFINES_SVH

// Register byte offsets
`define SVC_CTRL_OFS 12'h000
`define SVC_STATUS_A_OFS 12'h004
`define SVC_STATUS_B_OFS 12'h008
`define SVC_ID_OFS 12'h00C
`define SVC_MAILBOX0_OFS 12'h010
`define SVC_MAILBOX1_OFS 12'h014

// Control register fields (write one to act)
`define SVC_CTRL_ERASE_BIT 1

// Status A fields
`define SVC_STA_DONE_BIT 0
`define SVC_STA_CPU_HOLD_BIT 1
`define SVC_STA_PROTECTION_ERROR_FLAG_BIT 2

// Status B fields
`define SVC_STB_LOCKED_BIT 0
`define SVC_STB_PRESENT_BIT 1
`define SVC_STB_HOT_AVAIL_BIT 2
`define SVC_STB_ERASING_BIT 3

// Identity value, arbitrary
`define SVC_ID_VALUE 32'h0000_5A01

// Default lengths of the erase phases, in clock cycles
`define SVC_VOLATILE_CYCLES 16
`define SVC_FLASH_CYCLES 64
`define SVC_LOCKROW_CYCLES 16

// AXI responses
`define SVC_RESP_OKAY 2'b00
`define SVC_RESP_SLVERR 2'b10

`endif

// ==== hw/svc_pkg.sv ====
// Types shared by the debug service block and its bench.
// Assumes the offsets and fields in svc_defines.svh.
package svc_pkg;

	// Erase sequence, Gray-coded along the usual path
	typedef enum logic [1:0]
	{
		ERASE_IDLE = 2'b00,
		ERASE_VOLATILE = 2'b01,
		ERASE_FLASH = 2'b11,
		ERASE_LOCKROW = 2'b10
	} erase_state_e;

	// Strobes to the memory controllers
	typedef struct packed
	{
		logic clear_volatile;
		logic erase_flash;
		logic erase_lockrow;
	} erase_ctl_s;

	// Pin-side state of the probe link
	typedef struct packed
	{
		logic swclk;
		logic ext_reset_n;
	} probe_pins_s;

endpackage

// ==== hw/debug_service_reset_erase.sv ====
// Debug service logic: processor reset extension, probe detection and whole-chip erase.
// Assumes one 200 MHz clock, AXI4-Lite registers, asynchronous probe pins synchronised here.
//
// Notes on behaviour
// [RULE1] Release of external reset with debug clock low starts processor reset extension.
// [RULE2] cpu_hold_flag reads one while processor held in extension.
// [RULE3] Writing one to cpu_hold_flag releases processor and clears flag when unlocked.
// [RULE4] Writing zero to cpu_hold_flag changes nothing.
// [RULE5] Release attempt while locked is refused and sets protection_error_flag.
// [RULE6] Reset extension request counts as cold attach of a probe.
// [RULE7] Hot-attach detector held in reset during power-on or external reset.
// [RULE8] Outside reset, a falling debug clock edge registers hot attach when available.
// [RULE9] Pin reassigned or mux disabled disables hot attach until next reset.
// [RULE10] hot_attach_available in status_reg_b shows current hot attach availability.
// [RULE11] Cold or hot attach sets probe_present_flag in status_reg_b.
// [RULE12] Locked part keeps hot-attach path inactive; only cold attach detects.
// [RULE13] No probe detection before power-on reset released.
// [RULE14] Probe holds external reset past power-on release when locked, else retries.
// [RULE15] Writing one to erase_all_command starts whole-chip erase.
// [RULE16] Erase command ignored while access_guard write-protects the unit.
// [RULE17] Erase clears volatile memories, then flash with emulated area, then lock row.
// [RULE18] Erase-completion flag reads one once erase has finished.
// [RULE19] Probe should cold attach, erase, poll completion, then reset the device.
// [RULE20] access_guard blocks CPU writes except mailboxes, never debugger writes.
// [RULE21] Unit keeps working in sleep while its clock runs.
// [RULE22] New accepted erase clears completion flag; set again when it finishes.
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "svc_defines.svh"

module debug_service_reset_erase
#(
	parameter int unsigned VOLATILE_CYCLES = `SVC_VOLATILE_CYCLES,
	parameter int unsigned FLASH_CYCLES = `SVC_FLASH_CYCLES,
	parameter int unsigned LOCKROW_CYCLES = `SVC_LOCKROW_CYCLES
)
(
	input wire logic aclk,
	input wire logic aresetn,
	// Probe pins and system status
	input wire svc_pkg::probe_pins_s pins,
	input wire logic por_done,
	input wire logic security_locked,
	input wire logic pin_is_debug,
	input wire logic pin_mux_enabled,
	input wire logic access_guard,
	input wire logic erase_ack,
	// AXI4-Lite slave
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic s_axi_arprot_dbg,
	input wire logic s_axi_awprot_dbg,
	// System side
	output logic cpu_reset_hold,
	output svc_pkg::erase_ctl_s erase_ctl
);
	import svc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detection

	logic [1:0] swclk_sync_r;
	logic [1:0] rstn_sync_r;
	logic swclk_prev_r;
	logic rstn_prev_r;
	wire logic swclk_s = swclk_sync_r[1];
	wire logic rstn_s = rstn_sync_r[1];
	wire logic swclk_fall = swclk_prev_r & ~swclk_s;
	wire logic rstn_rise = ~rstn_prev_r & rstn_s;
	// Whole system considered in reset while power-on or external reset active
	wire logic sys_in_reset = ~por_done | ~rstn_s;

	// Two flops per pin; idle high so an open pin looks released
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			swclk_sync_r <= 2'h3;
			rstn_sync_r <= 2'h3;
			swclk_prev_r <= 1'b1;
			rstn_prev_r <= 1'b1;
		end
		else
		begin
			swclk_sync_r <= {swclk_sync_r[0], pins.swclk};
			rstn_sync_r <= {rstn_sync_r[0], pins.ext_reset_n};
			swclk_prev_r <= swclk_s;
			rstn_prev_r <= rstn_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register decode

	logic aw_held_r;
	logic w_held_r;
	logic [11:0] aw_addr_r;
	logic aw_dbg_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;

	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = (a == `SVC_CTRL_OFS) || (a == `SVC_STATUS_A_OFS) || (a == `SVC_STATUS_B_OFS) ||
			(a == `SVC_ID_OFS) || (a == `SVC_MAILBOX0_OFS) || (a == `SVC_MAILBOX1_OFS);
	endfunction

	function automatic logic is_mailbox(input logic [11:0] a);
		is_mailbox = (a == `SVC_MAILBOX0_OFS) || (a == `SVC_MAILBOX1_OFS);
	endfunction

	// Write fires once both halves are latched and no response is pending
	wire logic wr_fire = aw_held_r & w_held_r & ~s_axi_bvalid;
	wire logic wr_mapped = is_mapped(aw_addr_r);
	// Guard blocks CPU writes only; debugger and mailboxes always pass
	wire logic wr_blocked = access_guard & ~aw_dbg_r & ~is_mailbox(aw_addr_r); // [RULE20]
	wire logic wr_ok = wr_fire & wr_mapped & ~wr_blocked;
	wire logic lane0 = w_strb_r[0];
	wire logic wr_ctrl = wr_ok & lane0 & (aw_addr_r == `SVC_CTRL_OFS);
	wire logic wr_sta = wr_ok & lane0 & (aw_addr_r == `SVC_STATUS_A_OFS);
	wire logic erase_cmd = wr_ctrl & w_data_r[`SVC_CTRL_ERASE_BIT]; // [RULE15]
	wire logic hold_one = wr_sta & w_data_r[`SVC_STA_CPU_HOLD_BIT]; // [RULE4]
	wire logic protection_error_flag_one = wr_sta & w_data_r[`SVC_STA_PROTECTION_ERROR_FLAG_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// Reset extension and probe detection

	logic cpu_hold_r;
	logic protection_error_flag_r;
	logic present_r;
	logic hot_avail_r;
	logic hot_disabled_r;

	// Cold attach: external reset released with debug clock low, after power-on
	wire logic cold_attach = rstn_rise & ~swclk_s & por_done; // [RULE1] [RULE6] [RULE13]
	wire logic hot_ok = ~hot_disabled_r & ~security_locked & pin_is_debug & pin_mux_enabled; // [RULE12]
	wire logic hot_attach = hot_avail_r & ~sys_in_reset & swclk_fall; // [RULE8]
	wire logic release_ok = hold_one & cpu_hold_r & ~security_locked; // [RULE3]
	wire logic release_refused = hold_one & security_locked; // [RULE5]

	// Hold, error and presence flags; a new hold wins over a same-cycle release
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cpu_hold_r <= 1'b0;
			protection_error_flag_r <= 1'b0;
			present_r <= 1'b0;
		end
		else
		begin
			if (cold_attach)
				cpu_hold_r <= 1'b1; // [RULE2]
			else if (release_ok)
				cpu_hold_r <= 1'b0; // [RULE3]
			if (release_refused)
				protection_error_flag_r <= 1'b1; // [RULE5]
			else if (protection_error_flag_one)
				protection_error_flag_r <= 1'b0;
			if (cold_attach || hot_attach)
				present_r <= 1'b1; // [RULE11]
		end
	end

	// Hot-attach detector: cleared by any reset, latched off once the pin leaves debug
	always_ff @(posedge aclk)
	begin
		if (!aresetn || sys_in_reset)
		begin
			hot_disabled_r <= 1'b0; // [RULE7]
			hot_avail_r <= 1'b0;
		end
		else
		begin
			if (!pin_is_debug || !pin_mux_enabled)
				hot_disabled_r <= 1'b1; // [RULE9]
			hot_avail_r <= hot_ok; // [RULE10]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Whole-chip erase sequencer

	erase_state_e erase_state_r;
	erase_state_e erase_state_nxt;
	logic [15:0] erase_cnt_r;
	logic erase_done_r;
	erase_ctl_s erase_ctl_nxt;

	// Guarded CPU writes never reach here, so the guard refuses the command
	wire logic erase_start = erase_cmd & (erase_state_r == ERASE_IDLE); // [RULE16]
	wire logic phase_end = (erase_cnt_r == 16'h0000) & erase_ack;

	function automatic logic [15:0] phase_len(input erase_state_e s);
		case (s)
			ERASE_VOLATILE: phase_len = 16'(VOLATILE_CYCLES - 1);
			ERASE_FLASH: phase_len = 16'(FLASH_CYCLES - 1);
			ERASE_LOCKROW: phase_len = 16'(LOCKROW_CYCLES - 1);
			default: phase_len = 16'h0000;
		endcase
	endfunction

	// Volatile first, then flash, then the lock row
	always_comb
	begin
		erase_state_nxt = erase_state_r;
		case (erase_state_r)
			ERASE_IDLE: if (erase_start) erase_state_nxt = ERASE_VOLATILE; // [RULE17]
			ERASE_VOLATILE: if (phase_end) erase_state_nxt = ERASE_FLASH;
			ERASE_FLASH: if (phase_end) erase_state_nxt = ERASE_LOCKROW;
			ERASE_LOCKROW: if (phase_end) erase_state_nxt = ERASE_IDLE;
			default: erase_state_nxt = ERASE_IDLE;
		endcase
		erase_ctl_nxt.clear_volatile = (erase_state_nxt == ERASE_VOLATILE);
		erase_ctl_nxt.erase_flash = (erase_state_nxt == ERASE_FLASH);
		erase_ctl_nxt.erase_lockrow = (erase_state_nxt == ERASE_LOCKROW);
	end

	// Phase counter, completion flag and strobes
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			erase_state_r <= ERASE_IDLE;
			erase_cnt_r <= 16'h0000;
			erase_done_r <= 1'b0;
			erase_ctl <= '0;
		end
		else
		begin
			erase_state_r <= erase_state_nxt;
			erase_ctl <= erase_ctl_nxt;
			if (erase_state_nxt != erase_state_r)
				erase_cnt_r <= phase_len(erase_state_nxt);
			else if (erase_cnt_r != 16'h0000)
				erase_cnt_r <= erase_cnt_r - 16'h0001;
			if (erase_start)
				erase_done_r <= 1'b0; // [RULE22]
			else if (erase_state_r == ERASE_LOCKROW && phase_end)
				erase_done_r <= 1'b1; // [RULE18]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path

	logic [31:0] mailbox_r [2];

	// Channels latched independently; response after both
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= 12'h000;
			aw_dbg_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SVC_RESP_OKAY;
			mailbox_r[0] <= 32'h0000_0000;
			mailbox_r[1] <= 32'h0000_0000;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_r <= 1'b1;
				aw_addr_r <= {s_axi_awaddr[11:2], 2'b00};
				aw_dbg_r <= s_axi_awprot_dbg;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ? `SVC_RESP_OKAY : `SVC_RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wr_ok && is_mailbox(aw_addr_r))
			begin
				for (int b = 0; b < 4; b++)
				begin
					if (w_strb_r[b])
						mailbox_r[aw_addr_r[2]][8*b +: 8] <= w_data_r[8*b +: 8];
				end
			end
		end
	end

	// Ready registered: high while the channel is empty
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end
		else
		begin
			s_axi_awready <= ~aw_held_r & ~(s_axi_awvalid & s_axi_awready) & ~wr_fire;
			s_axi_wready <= ~w_held_r & ~(s_axi_wvalid & s_axi_wready) & ~wr_fire;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read path

	wire logic [11:0] rd_addr = {s_axi_araddr[11:2], 2'b00};
	wire logic [31:0] sta_word = {29'h0, protection_error_flag_r, cpu_hold_r, erase_done_r};
	wire logic [31:0] stb_word = {28'h0, erase_state_r != ERASE_IDLE, hot_avail_r, present_r, security_locked};
	logic [31:0] rd_word;

	// Read mux; unmapped reads return zero with an error
	always_comb
	begin
		case (rd_addr)
			`SVC_CTRL_OFS: rd_word = 32'h0000_0000;
			`SVC_STATUS_A_OFS: rd_word = sta_word;
			`SVC_STATUS_B_OFS: rd_word = stb_word;
			`SVC_ID_OFS: rd_word = `SVC_ID_VALUE;
			`SVC_MAILBOX0_OFS: rd_word = mailbox_r[0];
			`SVC_MAILBOX1_OFS: rd_word = mailbox_r[1];
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// One read at a time; arready only while no data pending
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `SVC_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= is_mapped(rd_addr) ? `SVC_RESP_OKAY : `SVC_RESP_SLVERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// Hold line registered; block needs only its clock, so sleep does not stop it
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cpu_reset_hold <= 1'b0;
		else
			cpu_reset_hold <= cpu_hold_r | ~rstn_s; // [RULE21]
	end

	// Unused fields of the arprot sideband kept for symmetry
	wire logic unused_arprot = s_axi_arprot_dbg;

endmodule

// ==== verification/debug_service_reset_erase_asserts.sv ====
// Checker for the debug service block, bound to its top module.
// Assumes the port names and types of that module.
`timescale 1ns/1ps
`include "svc_defines.svh"
module debug_service_reset_erase_asserts
	import svc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire svc_pkg::probe_pins_s pins,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic cpu_reset_hold,
	input wire logic erase_ack,
	input wire svc_pkg::erase_ctl_s erase_ctl
);
	import svc_pkg::*;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////
	// Steps of a bus write and of the erase
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_vol_end;
		$fell(erase_ctl.clear_volatile);
	endsequence
	sequence s_flash_end;
		$fell(erase_ctl.erase_flash);
	endsequence
	chk_phase_single: assert property ($onehot0(erase_ctl))
		else $error("two erase phases at once");
	chk_vol_then_flash: assert property (s_vol_end |-> erase_ctl.erase_flash)
		else $error("flash phase not after volatile");
	chk_flash_then_lock: assert property (s_flash_end |-> erase_ctl.erase_lockrow)
		else $error("lock row phase not after flash");
	// A phase may only end on the controller's acknowledge
	chk_phase_waits_ack: assert property (erase_ctl != 3'b000 && !erase_ack |=> $stable(erase_ctl))
		else $error("erase phase ended without acknowledge");
	chk_wr_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write not answered");
	chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	chk_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h020
		|=> s_axi_rresp == `SVC_RESP_SLVERR)
		else $error("unmapped read not refused");
	// Sync flops plus one register stage, one spare cycle
	chk_hold_ext_rst: assert property (!pins.ext_reset_n [*5] |-> cpu_reset_hold)
		else $error("processor not held in reset");
endmodule
bind debug_service_reset_erase debug_service_reset_erase_asserts chk_u (.aclk, .aresetn, .pins,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
	.s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
	.cpu_reset_hold, .erase_ack, .erase_ctl);

// ==== verification/probe_model.sv ====
// Model of the debug probe on the clock and reset pins.
// Assumes the bench calls its tasks right after a clock edge.
`timescale 1ns/1ps
module probe_model
	import svc_pkg::*;
(
	output svc_pkg::probe_pins_s pins,
	input wire logic por_done
);
	// Idle: clock pulled high, reset released
	initial
		pins = 2'h3;
	////////////////////////////////////////
	// Odd delays keep pin edges off the sampling edge
	task automatic cold_attach();
		#3;
		pins.swclk = 1'b0;
		pins.ext_reset_n = 1'b0;
		#403;
		// Locked parts only see a probe whose reset outlasts power-on
		wait (por_done === 1'b1);
		#403;
		pins.ext_reset_n = 1'b1;
		#403;
		pins.swclk = 1'b1;
	endtask
	// Frame of link clock at 80 ns, standing high between frames
	task automatic burst(input int n);
		#3;
		repeat (n)
		begin
			#40 pins.swclk = 1'b0;
			#40 pins.swclk = 1'b1;
		end
	endtask
endmodule

// ==== verification/debug_service_reset_erase_tb.sv ====
// Self-checking bench for the debug service block.
// Assumes the probe model and the bound checker.
`timescale 1ns/1ps
`include "svc_defines.svh"
module debug_service_reset_erase_tb;
	import svc_pkg::*;
	localparam logic [11:0] SA = `SVC_STATUS_A_OFS;
	localparam logic [11:0] SB = `SVC_STATUS_B_OFS;
	localparam int HLD = `SVC_STA_CPU_HOLD_BIT;
	localparam int PRES = `SVC_STB_PRESENT_BIT;
	localparam int HOT = `SVC_STB_HOT_AVAIL_BIT;
	localparam int DONE = `SVC_STA_DONE_BIT;
	logic aclk = '0, aresetn = '0, por_done = '1, locked = '0, pin_dbg = '1, mux_en = '1, guard = '0;
	logic awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0, awdbg = '0, eack = '1;
	logic [3:0] strb = 4'hf;
	logic [11:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata;
	logic awready, wready, bvalid, arready, rvalid, hold;
	logic [1:0] bresp, rresp, rr;
	probe_pins_s pins;
	erase_ctl_s ectl;
	int failures = 0, tests_run = 0, cyc = 0;
	always #2.5 aclk = ~aclk;
	probe_model prb_u (.pins(pins), .por_done(por_done));
	debug_service_reset_erase #(.VOLATILE_CYCLES(3), .FLASH_CYCLES(4), .LOCKROW_CYCLES(3)) dut_u
	(
		.aclk(aclk), .aresetn(aresetn), .pins(pins), .por_done(por_done), .security_locked(locked),
		.pin_is_debug(pin_dbg), .pin_mux_enabled(mux_en), .access_guard(guard), .erase_ack(eack),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .s_axi_arprot_dbg(awdbg), .s_axi_awprot_dbg(awdbg),
		.cpu_reset_hold(hold), .erase_ctl(ectl)
	);
	////////////////////////////////////////
	task automatic test_done();
		$display("Checks %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// Address and data released each on its own ready
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic dbg);
		awaddr <= a;
		wdata <= d;
		awdbg <= dbg;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		bready <= 1'b0;
		w(1);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		d = rdata;
		rr = rresp;
		rready <= 1'b0;
		w(1);
	endtask
	task automatic rb(input logic [11:0] a, input int b, input logic e);
		logic [31:0] d;
		rd(a, d);
		chk(d[b], e);
	endtask
	task automatic rst();
		aresetn <= 1'b0;
		w(10);
		aresetn <= 1'b1;
		w(1);
	endtask
	////////////////////////////////////////
	task automatic t_regs();
		logic [31:0] d;
		rd(`SVC_ID_OFS, d);
		chk(d, `SVC_ID_VALUE);
		rd(12'h020, d);
		chk(rr, `SVC_RESP_SLVERR);
		guard <= 1'b1;
		wr(`SVC_MAILBOX0_OFS, 32'h5A5A_1234, 1'b0);
		rd(`SVC_MAILBOX0_OFS, d);
		chk(d, 32'h5A5A_1234);
		// Byte strobes on the second mailbox keep the untouched lanes
		wr(`SVC_MAILBOX1_OFS, 32'hFFFF_FFFF, 1'b0);
		strb <= 4'h3;
		wr(`SVC_MAILBOX1_OFS, 32'h0000_1234, 1'b0);
		strb <= 4'hf;
		rd(`SVC_MAILBOX1_OFS, d);
		chk(d, 32'hFFFF_1234);
		guard <= 1'b0;
	endtask
	// Mux switched off and on again must not bring hot attach back
	task automatic t_hot();
		rb(SB, HOT, 1'b1);
		rb(SB, PRES, 1'b0);
		prb_u.burst(4);
		w(10);
		rb(SB, PRES, 1'b1);
		mux_en <= 1'b0;
		w(3);
		mux_en <= 1'b1;
		w(3);
		rb(SB, HOT, 1'b0);
	endtask
	task automatic t_cold();
		rst();
		prb_u.cold_attach();
		w(10);
		rb(SA, HLD, 1'b1);
		chk(hold, 1'b1);
		rb(SB, PRES, 1'b1);
		rb(SB, HOT, 1'b1);
		wr(SA, 32'h0000_0000, 1'b0);
		rb(SA, HLD, 1'b1);
		wr(SA, 32'h1 << HLD, 1'b0);
		rb(SA, HLD, 1'b0);
		chk(hold, 1'b0);
		// Pin taken away from debug also latches hot attach off
		pin_dbg <= 1'b0;
		w(3);
		pin_dbg <= 1'b1;
		w(3);
		rb(SB, HOT, 1'b0);
	endtask
	task automatic t_locked();
		por_done <= 1'b0;
		rst();
		prb_u.burst(4);
		w(10);
		rb(SB, PRES, 1'b0);
		// Locked and out of reset: a clock burst must not count as a probe
		locked <= 1'b1;
		por_done <= 1'b1;
		w(3);
		prb_u.burst(4);
		w(10);
		rb(SB, PRES, 1'b0);
		por_done <= 1'b0;
		fork
			prb_u.cold_attach();
			begin
				w(200);
				por_done <= 1'b1;
			end
		join
		w(10);
		rb(SB, PRES, 1'b1);
		rb(SB, HOT, 1'b0);
		wr(SA, 32'h1 << HLD, 1'b0);
		rb(SA, HLD, 1'b1);
		rb(SA, `SVC_STA_PROTECTION_ERROR_FLAG_BIT, 1'b1);
		chk(hold, 1'b1);
		locked <= 1'b0;
		wr(SA, 32'h1 << HLD, 1'b0);
		rb(SA, HLD, 1'b0);
	endtask
	// Guarded CPU erase is dropped; debugger erase runs twice
	task automatic t_erase();
		logic [31:0] d;
		int n;
		guard <= 1'b1;
		wr(`SVC_CTRL_OFS, 32'h1 << `SVC_CTRL_ERASE_BIT, 1'b0);
		rb(SB, `SVC_STB_ERASING_BIT, 1'b0);
		chk(ectl, 32'h0000_0000);
		for (int i = 0; i < 2; i++)
		begin
			eack <= (i == 0);
			wr(`SVC_CTRL_OFS, 32'h1 << `SVC_CTRL_ERASE_BIT, 1'b1);
			rb(SA, DONE, 1'b0);
			if (i == 1)
			begin
				// Controller withholds its acknowledge; the volatile phase must wait
				w(20);
				rb(SB, `SVC_STB_ERASING_BIT, 1'b1);
				chk(ectl, 32'h0000_0004);
				rb(SA, DONE, 1'b0);
				eack <= 1'b1;
			end
			n = 0;
			do
			begin
				rd(SA, d);
				n++;
			end
			while (d[DONE] !== 1'b1 && n < 50);
			chk(d[DONE], 1'b1);
		end
		guard <= 1'b0;
	endtask
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			test_done();
		end
	end
	initial
	begin
		rst();
		t_regs();
		t_hot();
		t_cold();
		t_locked();
		t_erase();
		test_done();
	end
endmodule
